// ---- srs_pkg.sv ----
package srs_pkg;

    // operation codes and service action
    localparam logic [7:0] OP_REPORT_ID    = 8'ha3;
    localparam logic [4:0] SA_REPORT_ID    = 5'h05;
    localparam logic [7:0] OP_REPORT_LUN   = 8'ha0;
    localparam logic [7:0] OP_REQ_SENSE    = 8'h03;

    // cdb byte positions
    localparam int unsigned CDB_BYTES      = 12;
    localparam int unsigned CDB_OPCODE     = 0;
    localparam int unsigned CDB_SVC        = 1;
    localparam int unsigned CDB_LUN_HI     = 4;
    localparam int unsigned CDB_LUN_LO     = 5;
    localparam int unsigned CDB_ALLOC_B3   = 6;
    localparam int unsigned CDB_ALLOC_B2   = 7;
    localparam int unsigned CDB_ALLOC_B1   = 8;
    localparam int unsigned CDB_ALLOC_B0   = 9;
    localparam int unsigned CDB_CU_BYTE    = 10;
    localparam int unsigned CDB_CU_BIT     = 1;
    localparam int unsigned CDB_SENSE_LEN  = 4;
    localparam int unsigned LUN_FIELD_SHFT = 5; // lun in byte 1 bits 7:5 for sense cdb

    // parameter data sizes
    localparam logic [31:0] LUN_MIN_ALLOC  = 32'h0000_0010;
    localparam logic [31:0] LUN_LIST_LEN   = 32'h0000_0008;
    localparam logic [31:0] LUN_LIST_TOTAL = 32'h0000_0010;
    localparam logic [31:0] SENSE_MAX      = 32'h0000_0020;
    localparam logic [31:0] ID_HDR_BYTES   = 32'h0000_0004;

    // sense keys and additional codes
    localparam logic [3:0] SK_NO_SENSE     = 4'h0;
    localparam logic [3:0] SK_NOT_READY    = 4'h2;
    localparam logic [3:0] SK_ILLEGAL_REQ  = 4'h5;
    localparam logic [7:0] ASC_NONE        = 8'h00;
    localparam logic [7:0] ASC_NOT_READY   = 8'h04;
    localparam logic [7:0] ASC_LUN_UNSUPP  = 8'h25;
    localparam logic [7:0] ASC_BAD_CDB     = 8'h24;

    // status codes
    localparam logic [7:0] ST_GOOD         = 8'h00;
    localparam logic [7:0] ST_CHECK        = 8'h02;

    // fixed sense layout positions
    localparam logic [7:0] SENSE_RESP_CODE = 8'h70;
    localparam logic [7:0] SENSE_ADD_LEN   = 8'h18;
    localparam int unsigned SB_KEY         = 2;
    localparam int unsigned SB_ADDLEN      = 7;
    localparam int unsigned SB_ASC         = 12;

    // command handler states
    typedef enum logic [1:0] {
        SRS_IDLE,
        SRS_DATA,
        SRS_STATUS
    } srs_state_t;

    // data source selection
    typedef enum logic [1:0] {
        SRS_SRC_ID,
        SRS_SRC_LUN,
        SRS_SRC_SENSE
    } srs_src_t;

endpackage

// ---- srs_sense_store.sv ----
`timescale 1ns/100ps
`default_nettype none

// per-initiator sense records: key and additional code, flops indexed by initiator
module srs_sense_store #(
    parameter int unsigned INIT_CNT = 16,
    parameter int unsigned IW       = 4
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          ce_in,
    // update port
    input  wire logic          set_in,
    input  wire logic          clr_in,
    input  wire logic [IW-1:0] wr_idx_in,
    input  wire logic [3:0]    key_in,
    input  wire logic [7:0]    asc_in,
    // lookup port
    input  wire logic [IW-1:0] rd_idx_in,
    output logic               rd_valid_out,
    output logic [3:0]         rd_key_out,
    output logic [7:0]         rd_asc_out
);

    initial begin
        if (INIT_CNT > (1 << IW) || INIT_CNT == 0) begin
            $error("srs_sense_store: INIT_CNT does not fit IW");
        end
    end

    logic [INIT_CNT-1:0] valid_q;
    logic [3:0]          key_q [INIT_CNT];
    logic [7:0]          asc_q [INIT_CNT];

    // one record per initiator, so one initiator never disturbs another
    genvar gi;
    generate
        for (gi = 0; gi < INIT_CNT; gi++) begin : g_rec
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    valid_q[gi] <= 1'b0;
                    key_q[gi]   <= srs_pkg::SK_NO_SENSE;
                    asc_q[gi]   <= srs_pkg::ASC_NONE;
                end else if (ce_in && wr_idx_in == IW'(gi)) begin
                    // set wins over clear in the same cycle
                    if (set_in) begin
                        valid_q[gi] <= 1'b1;
                        key_q[gi]   <= key_in;
                        asc_q[gi]   <= asc_in;
                    end else if (clr_in) begin
                        valid_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // combinational lookup, unknown index reads as empty
    always_comb begin
        rd_valid_out = 1'b0;
        rd_key_out   = srs_pkg::SK_NO_SENSE;
        rd_asc_out   = srs_pkg::ASC_NONE;
        if (int'(rd_idx_in) < INIT_CNT) begin
            rd_valid_out = valid_q[rd_idx_in];
            rd_key_out   = key_q[rd_idx_in];
            rd_asc_out   = asc_q[rd_idx_in];
        end
    end

endmodule

`default_nettype wire

// ---- srs_cmd.sv ----
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - opcode A3h with action 05h reports identifier
// - absent unit on identifier report: check condition
// - short allocation truncates, length field unchanged
// - select bit picks peripheral or component address
// - four-byte length header, then identifier bytes
// - length zero until successful set identifier
// - identifier persists, same for every initiator
// - store not ready: immediate check, not ready
// - lun report always accepted despite reservations
// - lun report allocation below 16 rejected
// - allocation of 16 or more sends the whole 16-byte list
// - lun list: length 8, reserved, unit zero
// - sense request sends min(allocation, 32) bytes
// - invalid unit sense request: good, unsupported
// - nothing pending returns no sense
// - any later report or sense command on nexus clears sense
// - separate sense record per initiator
// - sense after check condition, or bus free in a cycle with no report or sense command taken
module srs_cmd #(
    parameter int unsigned INIT_CNT = 16,
    parameter int unsigned IW       = 4,
    parameter int unsigned ID_MAX   = 16
) (
    // clock, reset, enable
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    // command descriptor block from the bus engine
    input  wire logic              cmd_valid_in,
    input  wire logic [IW-1:0]     cmd_init_in,
    input  wire logic [8*12-1:0]   cmd_cdb_in,
    input  wire logic              cmd_lun_present_in,
    input  wire logic              cmd_component_in,
    input  wire logic              cmd_component_present_in,
    // unexpected bus free seen on a nexus
    input  wire logic              bus_free_err_in,
    input  wire logic [IW-1:0]     bus_free_init_in,
    // nonvolatile identifier store
    input  wire logic              nv_ready_in,
    input  wire logic [31:0]       nv_id_len_in,
    input  wire logic [8*ID_MAX-1:0] nv_id_bytes_in,
    // parameter data to the initiator
    output logic                   data_valid_out,
    output logic [7:0]             data_byte_out,
    output logic                   data_last_out,
    input  wire logic              data_ready_in,
    // completion status
    output logic                   status_valid_out,
    output logic [7:0]             status_out,
    output logic                   busy_out
);

    initial begin
        if (ID_MAX == 0 || ID_MAX > 1024) begin
            $error("srs_cmd: ID_MAX out of range");
        end
    end

    srs_pkg::srs_state_t state_q;
    srs_pkg::srs_src_t   src_q;
    logic [31:0]         cnt_q, len_q;
    logic [IW-1:0]       init_q;
    logic [7:0]          stat_q, data_byte_q, snap_asc_q;
    logic                data_valid_q, data_last_q, status_valid_q, busy_q;
    logic [3:0]          snap_key_q;

    // cdb field extraction
    logic [7:0]  opcode;
    logic [4:0]  svc;
    logic [31:0] alloc32, alloc8;
    logic        lun_ok;
    assign opcode  = cmd_cdb_in[8*srs_pkg::CDB_OPCODE +: 8];
    assign svc     = cmd_cdb_in[8*srs_pkg::CDB_SVC +: 5];
    assign alloc32 = {cmd_cdb_in[8*srs_pkg::CDB_ALLOC_B3 +: 8],
                      cmd_cdb_in[8*srs_pkg::CDB_ALLOC_B2 +: 8],
                      cmd_cdb_in[8*srs_pkg::CDB_ALLOC_B1 +: 8],
                      cmd_cdb_in[8*srs_pkg::CDB_ALLOC_B0 +: 8]};
    assign alloc8  = {24'h00_0000, cmd_cdb_in[8*srs_pkg::CDB_SENSE_LEN +: 8]};
    // address space, resolved by the bus engine per select bit
    assign lun_ok  = cmd_component_in ? cmd_component_present_in : cmd_lun_present_in;
    // a command is only taken while idle and enabled
    logic take;
    assign take = ce_in && cmd_valid_in && state_q == srs_pkg::SRS_IDLE;
    // decoded command
    logic is_id, is_lun, is_sense;
    assign is_id    = opcode == srs_pkg::OP_REPORT_ID && svc == srs_pkg::SA_REPORT_ID;
    // lun report never looks at reservations
    assign is_lun   = opcode == srs_pkg::OP_REPORT_LUN;
    assign is_sense = opcode == srs_pkg::OP_REQ_SENSE;

    // sense record lookup and update
    logic          rd_valid, sense_set, sense_clr;
    logic [3:0]    rd_key, set_key;
    logic [7:0]    rd_asc, set_asc;
    logic [IW-1:0] wr_idx;
    srs_sense_store #(
        .INIT_CNT (INIT_CNT),
        .IW       (IW)
    ) u_store (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .ce_in        (ce_in),
        .set_in       (sense_set),
        .clr_in       (sense_clr),
        .wr_idx_in    (wr_idx),
        .key_in       (set_key),
        .asc_in       (set_asc),
        .rd_idx_in    (cmd_init_in),
        .rd_valid_out (rd_valid),
        .rd_key_out   (rd_key),
        .rd_asc_out   (rd_asc)
    );

    // decide errors for the incoming command
    logic       err;
    logic [3:0] err_key;
    logic [7:0] err_asc;
    always_comb begin
        err     = 1'b0;
        err_key = srs_pkg::SK_NO_SENSE;
        err_asc = srs_pkg::ASC_NONE;
        if (is_id && !lun_ok) begin
            err     = 1'b1;
            err_key = srs_pkg::SK_ILLEGAL_REQ;
            err_asc = srs_pkg::ASC_LUN_UNSUPP;
        end else if (is_id && !nv_ready_in) begin
            err     = 1'b1;
            err_key = srs_pkg::SK_NOT_READY;
            err_asc = srs_pkg::ASC_NOT_READY;
        end else if (is_lun && alloc32 < srs_pkg::LUN_MIN_ALLOC) begin
            err     = 1'b1;
            err_key = srs_pkg::SK_ILLEGAL_REQ;
            err_asc = srs_pkg::ASC_BAD_CDB;
        end
    end

    // a taken report or sense command clears; check or bus free sets; bus free has its own index
    always_comb begin
        sense_set = 1'b0;
        sense_clr = 1'b0;
        wr_idx    = cmd_init_in;
        set_key   = err_key;
        set_asc   = err_asc;
        if (take && (is_id || is_lun || is_sense)) begin
            sense_clr = 1'b1;
            sense_set = err;
        end else if (bus_free_err_in) begin
            // aborted command reported as an aborted-style illegal request record
            wr_idx    = bus_free_init_in;
            sense_set = 1'b1;
            set_key   = srs_pkg::SK_ILLEGAL_REQ;
            set_asc   = srs_pkg::ASC_NONE;
        end
    end

    // transfer length: min of allocation and available data
    logic [31:0] avail, alloc_sel, xfer_len;
    always_comb begin
        avail     = srs_pkg::SENSE_MAX;
        alloc_sel = alloc8;
        if (is_id) begin
            avail     = srs_pkg::ID_HDR_BYTES + nv_id_len_in;
            alloc_sel = alloc32;
        end else if (is_lun) begin
            avail     = srs_pkg::LUN_LIST_TOTAL;
            alloc_sel = alloc32;
        end
        xfer_len = (alloc_sel < avail) ? alloc_sel : avail;
    end

    // command state machine
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= srs_pkg::SRS_IDLE;
            src_q   <= srs_pkg::SRS_SRC_SENSE;
            len_q   <= 32'h0000_0000;
            init_q  <= '0;
            stat_q  <= srs_pkg::ST_GOOD;
            busy_q  <= 1'b0;
        end else if (ce_in) begin
            case (state_q)
                srs_pkg::SRS_IDLE: begin
                    if (take && (is_id || is_lun || is_sense)) begin
                        init_q <= cmd_init_in;
                        busy_q <= 1'b1;
                        len_q  <= xfer_len;
                        src_q  <= is_id ? srs_pkg::SRS_SRC_ID :
                                  (is_lun ? srs_pkg::SRS_SRC_LUN : srs_pkg::SRS_SRC_SENSE);
                        if (err) begin
                            stat_q  <= srs_pkg::ST_CHECK;
                            state_q <= srs_pkg::SRS_STATUS;
                        end else begin
                            // good after data; sense always good
                            stat_q  <= srs_pkg::ST_GOOD;
                            state_q <= (xfer_len == 32'h0000_0000) ? srs_pkg::SRS_STATUS
                                                                   : srs_pkg::SRS_DATA;
                        end
                    end
                end
                srs_pkg::SRS_DATA: begin
                    if (data_valid_q && data_ready_in && data_last_q) begin
                        state_q <= srs_pkg::SRS_STATUS;
                    end
                end
                srs_pkg::SRS_STATUS: begin
                    state_q <= srs_pkg::SRS_IDLE;
                    busy_q  <= 1'b0; // kept in a flop so busy_out never glitches
                end
                default: begin
                    state_q <= srs_pkg::SRS_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // snapshot of the sense to report, taken before the clear lands
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            snap_key_q <= srs_pkg::SK_NO_SENSE;
            snap_asc_q <= srs_pkg::ASC_NONE;
        end else if (take && is_sense) begin
            if (!lun_ok) begin
                snap_key_q <= srs_pkg::SK_ILLEGAL_REQ;
                snap_asc_q <= srs_pkg::ASC_LUN_UNSUPP;
            end else if (rd_valid) begin
                snap_key_q <= rd_key;
                snap_asc_q <= rd_asc;
            end else begin
                snap_key_q <= srs_pkg::SK_NO_SENSE;
                snap_asc_q <= srs_pkg::ASC_NONE;
            end
        end
    end

    // byte generator for the current source
    logic [7:0]  next_byte;
    logic [31:0] id_off;
    always_comb begin
        next_byte = 8'h00;
        id_off    = cnt_q - srs_pkg::ID_HDR_BYTES;
        case (src_q)
            srs_pkg::SRS_SRC_ID: begin
                // big-endian length then bytes from the shared store
                if (cnt_q < srs_pkg::ID_HDR_BYTES) begin
                    next_byte = nv_id_len_in[8*(3-cnt_q[1:0]) +: 8];
                end else if (id_off < ID_MAX) begin
                    next_byte = nv_id_bytes_in[8*id_off[9:0] +: 8];
                end
            end
            srs_pkg::SRS_SRC_LUN: begin
                // length 8, reserved, unit zero entry
                if (cnt_q < srs_pkg::ID_HDR_BYTES) begin
                    next_byte = srs_pkg::LUN_LIST_LEN[8*(3-cnt_q[1:0]) +: 8];
                end
            end
            srs_pkg::SRS_SRC_SENSE: begin
                if (cnt_q == 32'h0000_0000) begin
                    next_byte = srs_pkg::SENSE_RESP_CODE;
                end else if (cnt_q == srs_pkg::SB_KEY) begin
                    next_byte = {4'h0, snap_key_q};
                end else if (cnt_q == srs_pkg::SB_ADDLEN) begin
                    next_byte = srs_pkg::SENSE_ADD_LEN;
                end else if (cnt_q == srs_pkg::SB_ASC) begin
                    next_byte = snap_asc_q;
                end
            end
            default: begin
                next_byte = 8'h00;
            end
        endcase
    end

    // data stream with valid/ready handshake
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q        <= 32'h0000_0000;
            data_valid_q <= 1'b0;
            data_byte_q  <= 8'h00;
            data_last_q  <= 1'b0;
        end else if (ce_in) begin
            if (state_q != srs_pkg::SRS_DATA) begin
                cnt_q        <= 32'h0000_0000;
                data_valid_q <= 1'b0;
                data_last_q  <= 1'b0;
            end else if (!data_valid_q || (data_ready_in && !data_last_q)) begin
                data_valid_q <= 1'b1;
                data_byte_q  <= next_byte;
                data_last_q  <= (cnt_q + 32'h0000_0001) == len_q;
                cnt_q        <= cnt_q + 32'h0000_0001;
            end else if (data_ready_in) begin
                data_valid_q <= 1'b0;
                data_last_q  <= 1'b0;
            end
        end
    end

    // status pulse, one cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            status_valid_q <= 1'b0;
        end else if (ce_in) begin
            status_valid_q <= state_q == srs_pkg::SRS_STATUS;
        end
    end

    assign data_valid_out   = data_valid_q;
    assign data_byte_out    = data_byte_q;
    assign data_last_out    = data_last_q;
    assign status_valid_out = status_valid_q;
    assign status_out       = stat_q;
    assign busy_out         = busy_q;

    // assertions
    sequence s_short_lun;
        take && is_lun && alloc32 < srs_pkg::LUN_MIN_ALLOC;
    endsequence

    a_lun_short_check: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_short_lun ##1 ce_in [*2] |-> status_valid_q && stat_q == srs_pkg::ST_CHECK)
        else $error("short lun allocation not checked");
    a_id_absent_unit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && is_id && !lun_ok
        |=> state_q == srs_pkg::SRS_STATUS && stat_q == srs_pkg::ST_CHECK)
        else $error("absent unit not checked");
    a_nv_no_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && is_id && lun_ok && !nv_ready_in |=> state_q == srs_pkg::SRS_STATUS)
        else $error("not ready store waited");
    a_sense_good_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && is_sense |=> stat_q == srs_pkg::ST_GOOD)
        else $error("sense request not good");
    a_sense_len_cap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == srs_pkg::SRS_DATA && src_q == srs_pkg::SRS_SRC_SENSE
        |-> len_q <= srs_pkg::SENSE_MAX)
        else $error("sense longer than 32");
    a_lun_list_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        data_valid_q && src_q == srs_pkg::SRS_SRC_LUN && cnt_q == 32'h0000_0004
        |-> data_byte_q == srs_pkg::LUN_LIST_LEN[7:0])
        else $error("lun list length byte wrong");
    a_sense_cleared: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && !err && (is_id || is_lun || is_sense) && !bus_free_err_in
        |=> !u_store.valid_q[$past(cmd_init_in)])
        else $error("sense not cleared");
    a_check_sets_sense: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take && err |=> u_store.valid_q[$past(cmd_init_in)])
        else $error("check left no sense");
    a_good_after_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_q == srs_pkg::SRS_DATA && ce_in && data_valid_q && data_ready_in && data_last_q
        |=> ##1 (status_valid_q && stat_q == srs_pkg::ST_GOOD) || !ce_in)
        else $error("no status after data");

endmodule

`default_nettype wire

// ---- srs_host.sv ----
`timescale 1ns/100ps
`default_nettype none

// initiator side of the data phase: collects bytes and may stall
module srs_host (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // data phase
    input  wire logic       data_valid_in,
    input  wire logic [7:0] data_byte_in,
    input  wire logic       slow_in,
    output logic            data_ready_out
);
    logic [7:0] rx_q [$];

    initial data_ready_out = 1'b0;

    // slow mode drops ready on about half the cycles so bytes must hold
    always @(posedge clk_in) begin
        data_ready_out <= rst_n_in && (!slow_in || $urandom_range(1) == 1);
        if (rst_n_in && data_valid_in && data_ready_out) begin
            rx_q.push_back(data_byte_in);
        end
    end
endmodule
`default_nettype wire

// ---- scsi_report_and_sense_cmds_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module scsi_report_and_sense_cmds_bench;
    logic         clk, rst_n, ce, cmd_valid, lun_p, comp, comp_p, bf_err, nv_ready;
    logic         slow, dv, dl, dr, sv, busy;
    logic [3:0]   init, bf_init;
    logic [95:0]  cdb;
    logic [31:0]  id_len;
    logic [127:0] id_bytes;
    logic [7:0]   db, st;
    int           num_errors = 0;
    int           checked = 0;
    int           cyc = 0;
    int           last_seen = 0;

    srs_cmd #(.INIT_CNT(16), .IW(4), .ID_MAX(16)) i_dut (
        .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .cmd_valid_in(cmd_valid),
        .cmd_init_in(init), .cmd_cdb_in(cdb), .cmd_lun_present_in(lun_p),
        .cmd_component_in(comp), .cmd_component_present_in(comp_p),
        .bus_free_err_in(bf_err), .bus_free_init_in(bf_init), .nv_ready_in(nv_ready),
        .nv_id_len_in(id_len), .nv_id_bytes_in(id_bytes), .data_valid_out(dv),
        .data_byte_out(db), .data_last_out(dl), .data_ready_in(dr),
        .status_valid_out(sv), .status_out(st), .busy_out(busy));

    srs_host i_host (.clk_in(clk), .rst_n_in(rst_n), .data_valid_in(dv),
        .data_byte_in(db), .slow_in(slow), .data_ready_out(dr));

    // clock generator
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // hang guard, well above the longest expected run; also counts accepted last bytes
    always @(posedge clk) begin
        cyc++;
        if (rst_n && dv && dr && dl) begin
            last_seen++;
        end
        if (cyc > 30000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [95:0] mk_cdb(logic [7:0] op, b1, logic [31:0] al, logic cu);
        logic [95:0] c;
        c = '0;
        c[7:0] = op;
        c[15:8] = b1;
        if (op == srs_pkg::OP_REQ_SENSE) begin
            c[39:32] = al[7:0];
        end else begin
            c[79:48] = {al[7:0], al[15:8], al[23:16], al[31:24]};
        end
        c[81] = cu;
        return c;
    endfunction

    // big endian length header, then stored bytes
    function automatic logic [7:0] exp_id(int i, logic [31:0] ln);
        return (i < 4) ? 8'(ln >> (8 * (3 - i))) : id_bytes[8 * (i - 4) +: 8];
    endfunction

    // one command, waits for status, compares status and byte count
    task automatic run(logic [3:0] ini, logic [95:0] c, logic lp, cp, logic [7:0] es, int n);
        int k;
        @(posedge clk);
        i_host.rx_q.delete();
        last_seen = 0;
        init <= ini;
        cdb <= c;
        lun_p <= lp;
        comp <= c[81];
        comp_p <= cp;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
            if (k == 1) begin
                check("busy after take", busy, 1'b1);
            end
        end while (sv !== 1'b1 && k < 400);
        check("status seen", sv, 1'b1);
        check("busy after status", busy, 1'b0);
        check("status", st, es);
        check("byte count", i_host.rx_q.size(), n);
        check("last marker", last_seen, n > 0);
    endtask

    task automatic sense(logic [3:0] ini, logic [3:0] key, logic [7:0] asc);
        run(ini, mk_cdb(srs_pkg::OP_REQ_SENSE, 8'h00, 32, 1'b0), 1'b1, 1'b0,
            srs_pkg::ST_GOOD, 32);
        check("sense key", i_host.rx_q[2], {4'h0, key});
        check("sense asc", i_host.rx_q[12], asc);
    endtask

    // main sequence
    initial begin
        int al;
        int ln;
        int n;
        void'($urandom(32'h48aa6c96));
        {rst_n, cmd_valid, lun_p, comp, comp_p, bf_err, slow} = '0;
        {init, bf_init, cdb, id_len, id_bytes} = '0;
        ce = 1'b1;
        nv_ready = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        slow <= 1'b1;
        run(4'h1, mk_cdb(8'ha0, 8'h00, 16, 1'b0), 1'b1, 1'b0, srs_pkg::ST_GOOD, 16);
        for (int i = 0; i < 16; i++) begin
            check("lun list", i_host.rx_q[i], (i == 3) ? 8'h08 : 8'h00);
        end
        al = 16 + $urandom_range(200);
        run(4'h1, mk_cdb(8'ha0, 8'h00, al, 1'b0), 1'b1, 1'b0, srs_pkg::ST_GOOD, 16);
        run(4'h2, mk_cdb(8'ha0, 8'h00, 15, 1'b0), 1'b1, 1'b0, srs_pkg::ST_CHECK, 0);
        sense(4'h1, srs_pkg::SK_NO_SENSE, srs_pkg::ASC_NONE);
        sense(4'h2, srs_pkg::SK_ILLEGAL_REQ, srs_pkg::ASC_BAD_CDB);
        sense(4'h2, srs_pkg::SK_NO_SENSE, srs_pkg::ASC_NONE);
        // random identifiers, allocations and initiators, both address kinds
        for (int t = 0; t < 12; t++) begin
            @(posedge clk);
            ln = (t == 1) ? 0 : $urandom_range(16);
            al = (t == 0) ? 0 : $urandom_range(24);
            id_len <= ln;
            id_bytes <= {$urandom, $urandom, $urandom, $urandom};
            slow <= t[0];
            n = (al < ln + 4) ? al : ln + 4;
            run(4'($urandom), mk_cdb(8'ha3, 8'h05, al, t[1]), !t[1], t[1], 8'h00, n);
            for (int i = 0; i < n; i++) begin
                check("id data", i_host.rx_q[i], exp_id(i, ln));
            end
            if (n < ln + 4) begin
                // ask again with room for the whole identifier
                run(4'h9, mk_cdb(8'ha3, 8'h05, ln + 4, 1'b0), 1'b1, 1'b0, 8'h00, ln + 4);
                check("id length", i_host.rx_q[3], 8'(ln));
            end
        end
        run(4'h3, mk_cdb(8'ha3, 8'h05, 32, 1'b0), 1'b0, 1'b1, srs_pkg::ST_CHECK, 0);
        run(4'h4, mk_cdb(8'ha3, 8'h05, 32, 1'b1), 1'b1, 1'b0, srs_pkg::ST_CHECK, 0);
        sense(4'h3, srs_pkg::SK_ILLEGAL_REQ, srs_pkg::ASC_LUN_UNSUPP);
        sense(4'h4, srs_pkg::SK_ILLEGAL_REQ, srs_pkg::ASC_LUN_UNSUPP);
        @(posedge clk);
        nv_ready <= 1'b0;
        run(4'h5, mk_cdb(8'ha3, 8'h05, 32, 1'b0), 1'b1, 1'b0, srs_pkg::ST_CHECK, 0);
        @(posedge clk);
        nv_ready <= 1'b1;
        sense(4'h5, srs_pkg::SK_NOT_READY, srs_pkg::ASC_NOT_READY);
        // missing unit on a sense request, allocation around the 32 byte cap
        al = $urandom_range(13, 60);
        n = (al < 32) ? al : 32;
        run(4'h6, mk_cdb(8'h03, 8'h00, al, 1'b0), 1'b0, 1'b0, srs_pkg::ST_GOOD, n);
        check("bad unit key", i_host.rx_q[2], 8'h05);
        check("bad unit asc", i_host.rx_q[12], srs_pkg::ASC_LUN_UNSUPP);
        // unexpected bus free leaves a record for that initiator only
        @(posedge clk);
        bf_init <= 4'h7;
        bf_err <= 1'b1;
        @(posedge clk);
        bf_err <= 1'b0;
        sense(4'h8, srs_pkg::SK_NO_SENSE, srs_pkg::ASC_NONE);
        sense(4'h7, srs_pkg::SK_ILLEGAL_REQ, srs_pkg::ASC_NONE);
        stop_test();
    end
endmodule
`default_nettype wire
